// [sse_pkg.sv]
// Shared constants for the sleep, subtract and nibble-exchange executor
package sse_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_INSTR = 8'h04;
    localparam logic [7:0] OFF_ACC = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_OPTION = 8'h10;
    localparam logic [7:0] OFF_WDOG = 8'h14;
    localparam logic [7:0] OFF_FILE_BASE = 8'h80;
    // Status field positions
    localparam int ST_CARRY = 0;
    localparam int ST_HALF = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_POWERDOWN = 3;
    localparam int ST_EXPIRED = 4;
    localparam int ST_W = 5;
    // Option and control field positions
    localparam int OPT_PSA = 0;
    localparam int CTRL_ASLEEP = 0;
    // Values after reset
    localparam logic [4:0] STATUS_RST = 5'h18;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic OPT_PSA_RST = 1'b1;
    localparam logic [11:0] INSTR_RST = 12'h000;
    // Instruction encodings
    localparam logic [11:0] OP_SLEEP = 12'h003;
    localparam logic [5:0] OP_SUB_HI = 6'h02;
    localparam logic [5:0] OP_SWAP_HI = 6'h0e;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int WDOG_TICK_NS = 1000;
    localparam int WDOG_TICK_CYCLES =
        (WDOG_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        SSE_OP_NONE = 3'b001,
        SSE_OP_SUB = 3'b010,
        SSE_OP_SWAP = 3'b100
    } sse_op_e;
endpackage

// [sse_exec_if.sv]
// Operand and result bundle between the decoder and the arithmetic unit
`timescale 1ns/10ps
interface sse_exec_if;
    logic [7:0] file_val;
    logic [7:0] acc_val;
    sse_pkg::sse_op_e op;
    logic [7:0] result;
    logic carry;
    logic half_carry;
    logic zero;
    modport ctl (
        output file_val,
        output acc_val,
        output op,
        input result,
        input carry,
        input half_carry,
        input zero
    );
    modport alu (
        input file_val,
        input acc_val,
        input op,
        output result,
        output carry,
        output half_carry,
        output zero
    );
endinterface

// [sse_alu.sv]
// Subtract and nibble-exchange datapath
`timescale 1ns/10ps
module sse_alu (
    sse_exec_if.alu ex
);
    wire [8:0] full_diff;
    wire [4:0] low_diff;
    wire [7:0] swapped;
    assign full_diff = {1'b0, ex.file_val} - {1'b0, ex.acc_val};
    assign low_diff = {1'b0, ex.file_val[3:0]} - {1'b0, ex.acc_val[3:0]};
    assign swapped = {ex.file_val[3:0], ex.file_val[7:4]};
    assign ex.result = (ex.op == sse_pkg::SSE_OP_SWAP) ? swapped :
        full_diff[7:0];
    assign ex.carry = ~full_diff[8];
    assign ex.half_carry = ~low_diff[4];
    assign ex.zero = (full_diff[7:0] == 8'h00);
endmodule // sse_alu

// [sse_wdog.sv]
// Watchdog counter with optional prescaler in front of it
`timescale 1ns/10ps
module sse_wdog #(
    parameter int TICK_CYCLES = sse_pkg::WDOG_TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clear,
    input wire logic psa_wdog,
    output logic [7:0] count,
    output logic [7:0] prescale,
    output logic timeout
);
    logic [15:0] div_reg;
    logic tick;
    wire pre_wrap;
    wire step;
    assign tick = (div_reg == 16'(TICK_CYCLES - 1));
    assign pre_wrap = (prescale == 8'hff);
    assign step = tick && (!psa_wdog || pre_wrap);
    assign timeout = step && (count == 8'hff) && !clear;
    always_ff @(posedge aclk) begin
        if (!aresetn || tick) begin
            div_reg <= 16'h0000;
        end else begin
            div_reg <= div_reg + 16'h0001;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 8'h00;
            prescale <= 8'h00;
        end else if (clear) begin
            count <= 8'h00;
            if (psa_wdog) begin
                prescale <= 8'h00;
            end
        end else begin
            if (tick && psa_wdog) begin
                prescale <= prescale + 8'h01;
            end
            if (step) begin
                count <= count + 8'h01;
            end
        end
    end
endmodule // sse_wdog

// [sse_top.sv]
// Instruction executor for sleep, subtract and nibble exchange, AXI4-Lite
// How it works
// - Word 003h halts oscillator, one cycle
// - Low-power sets expired flag, clears powerdown
// - Low-power zeroes watchdog, prescaler if assigned
// - Subtract computes file minus accumulator, flags
// - Subtract destination bit selects accumulator or file
// - Exchange swaps upper and lower nibbles
// - Exchange destination selects target, flags untouched
// - Carry is one when no borrow
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
module sse_top #(
    parameter int TICK_CYCLES = sse_pkg::WDOG_TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic osc_run
);
    sse_exec_if ex ();

    // Architectural state
    logic [7:0] file_mem [0:31];
    logic [7:0] acc_reg;
    logic [4:0] status_reg;
    logic psa_reg;
    logic asleep_reg;
    logic [11:0] instr_reg;
    logic exec_reg;

    // Write channel holding
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    wire [7:0] wd_count;
    wire [7:0] wd_prescale;
    wire wd_timeout;

    // Decode of the pending instruction
    wire [4:0] op_file;
    wire op_dest_file;
    wire is_sleep;
    wire is_sub;
    wire is_swap;
    wire run;
    assign op_file = instr_reg[4:0];
    assign op_dest_file = instr_reg[5];
    assign is_sleep = (instr_reg == sse_pkg::OP_SLEEP);
    assign is_sub = (instr_reg[11:6] == sse_pkg::OP_SUB_HI);
    assign is_swap = (instr_reg[11:6] == sse_pkg::OP_SWAP_HI);
    assign run = exec_reg && !asleep_reg;
    wire do_sleep;
    wire do_alu;
    assign do_sleep = run && is_sleep;
    assign do_alu = run && (is_sub || is_swap);

    assign ex.file_val = file_mem[op_file];
    assign ex.acc_val = acc_reg;
    assign ex.op = is_sub ? sse_pkg::SSE_OP_SUB :
        is_swap ? sse_pkg::SSE_OP_SWAP : sse_pkg::SSE_OP_NONE;

    sse_alu u_alu (
        .ex(ex)
    );

    sse_wdog #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_wdog (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(do_sleep),
        .psa_wdog(psa_reg),
        .count(wd_count),
        .prescale(wd_prescale),
        .timeout(wd_timeout)
    );

    // Register read mux, shared by reads and byte-lane merging
    function automatic logic [31:0] reg_view(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a[7]) begin
            v = {24'h000000, file_mem[a[6:2]]};
        end else begin
            case (a)
                sse_pkg::OFF_CTRL: v = {31'h0, asleep_reg};
                sse_pkg::OFF_INSTR: v = {20'h00000, instr_reg};
                sse_pkg::OFF_ACC: v = {24'h000000, acc_reg};
                sse_pkg::OFF_STATUS: v = {27'h0000000, status_reg};
                sse_pkg::OFF_OPTION: v = {31'h0, psa_reg};
                sse_pkg::OFF_WDOG: v = {16'h0000, wd_prescale, wd_count};
                default: v = 32'h0000_0000;
            endcase
        end
        return v;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        logic m;
        m = a[7] || (a[1:0] == 2'h0 && a <= sse_pkg::OFF_WDOG);
        return m && (a[1:0] == 2'h0);
    endfunction

    // AXI4-Lite handshakes
    wire do_write;
    logic [31:0] old_word;
    wire [31:0] new_word;
    wire wr_ok;
    wire wr_ctrl;
    wire wr_instr;
    wire wr_acc;
    wire wr_status;
    wire wr_option;
    wire wr_file;
    wire ar_take;
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    assign ar_take = s_axi_arvalid && !rvalid_reg;
    // Procedural so that the merge follows every register the view reads
    always_comb begin
        old_word = reg_view(aw_addr_reg);
    end
    genvar gi;
    for (gi = 0; gi < 4; gi++) begin : g_lane
        assign new_word[gi*8 +: 8] = w_strb_reg[gi] ?
            w_data_reg[gi*8 +: 8] : old_word[gi*8 +: 8];
    end
    assign wr_ok = do_write && mapped(aw_addr_reg);
    assign wr_ctrl = wr_ok && (aw_addr_reg == sse_pkg::OFF_CTRL);
    assign wr_instr = wr_ok && (aw_addr_reg == sse_pkg::OFF_INSTR);
    assign wr_acc = wr_ok && (aw_addr_reg == sse_pkg::OFF_ACC);
    assign wr_status = wr_ok && (aw_addr_reg == sse_pkg::OFF_STATUS);
    assign wr_option = wr_ok && (aw_addr_reg == sse_pkg::OFF_OPTION);
    assign wr_file = wr_ok && aw_addr_reg[7];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= sse_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= mapped(aw_addr_reg) ? sse_pkg::RESP_OKAY :
                sse_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= sse_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= reg_view(s_axi_araddr);
            rresp_reg <= mapped(s_axi_araddr) ? sse_pkg::RESP_OKAY :
                sse_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Instruction issue: a write to the instruction word runs it next edge unless asleep
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_reg <= sse_pkg::INSTR_RST;
            exec_reg <= 1'b0;
        end else begin
            exec_reg <= wr_instr;
            if (wr_instr) begin
                instr_reg <= new_word[11:0];
            end
        end
    end

    // Sleep state; oscillator stays halted until woken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            asleep_reg <= 1'b0;
        end else if (do_sleep) begin
            asleep_reg <= 1'b1;
        end else if (wd_timeout) begin
            asleep_reg <= 1'b0;
        end else if (wr_ctrl && !new_word[sse_pkg::CTRL_ASLEEP]) begin
            asleep_reg <= 1'b0;
        end
    end
    assign osc_run = !asleep_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            psa_reg <= sse_pkg::OPT_PSA_RST;
        end else if (wr_option) begin
            psa_reg <= new_word[sse_pkg::OPT_PSA];
        end
    end

    // Accumulator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_reg <= sse_pkg::ACC_RST;
        end else if (do_alu && !op_dest_file) begin
            acc_reg <= ex.result;
        end else if (wr_acc) begin
            acc_reg <= new_word[7:0];
        end
    end

    // File registers
    always_ff @(posedge aclk) begin
        if (do_alu && op_dest_file) begin
            file_mem[op_file] <= ex.result;
        end else if (wr_file) begin
            file_mem[aw_addr_reg[6:2]] <= new_word[7:0];
        end
    end

    // Status flags; swap leaves all of them alone
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= sse_pkg::STATUS_RST;
        end else if (do_sleep) begin
            status_reg[sse_pkg::ST_EXPIRED] <= 1'b1;
            status_reg[sse_pkg::ST_POWERDOWN] <= 1'b0;
        end else if (run && is_sub) begin
            status_reg[sse_pkg::ST_CARRY] <= ex.carry;
            status_reg[sse_pkg::ST_HALF] <= ex.half_carry;
            status_reg[sse_pkg::ST_ZERO] <= ex.zero;
        end else if (wd_timeout) begin
            status_reg[sse_pkg::ST_EXPIRED] <= 1'b0;
        end else if (wr_status) begin
            status_reg <= new_word[sse_pkg::ST_W-1:0];
        end
    end
endmodule // sse_top

// [sse_top_assertions.sv]
// Bus and sleep checks on the executor's top-level ports
`timescale 1ns/10ps
module sse_top_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic osc_run
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready;
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped");
    ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("arready wrong");
    w_refuse_a: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write not refused");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    wr_answer_a: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == 8'h40 |=> s_axi_rresp == sse_pkg::RESP_SLVERR &&
        s_axi_rdata == 32'h0) else $error("unmapped read answered");
    sleep_stop_a: assert property (
        wr_both && s_axi_awaddr == sse_pkg::OFF_INSTR && osc_run &&
        s_axi_wdata[11:0] == sse_pkg::OP_SLEEP |-> ##[1:3] !osc_run)
        else $error("oscillator not halted");
    osc_reset_a: assert property ($rose(aresetn) |-> osc_run)
        else $error("oscillator not running after reset");
endmodule // sse_top_assertions
bind sse_top sse_top_assertions u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .osc_run(osc_run));

// [sse_top_test.sv]
// Register-level test of the sleep, subtract and exchange executor
`timescale 1ns/10ps
module sse_top_test;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, osc_run;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int num_errors = 0;
    int comparisons = 0;
    logic [31:0] rd_mask = 32'hffff_ffff;
    logic [31:0] last_rd = 32'h0;
    localparam logic [31:0] SUBT [6] = '{32'h0302_0101, 32'h0202_0002,
        32'h0102_011f, 32'h1001_0003, 32'h0000_0100, 32'h0f10_0004};
    localparam logic [31:0] SWPT [2] = '{32'ha500_0005, 32'h3c00_011e};
    sse_top #(.TICK_CYCLES(2)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .osc_run(osc_run));
    initial begin
        forever #5 aclk = ~aclk;
    end
    task automatic give_verdict();
        $display("Comparisons %0d, errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Payload held until each channel's own ready is seen high
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
        bready <= 1'b0;
        check({30'h0, r}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
            input logic [1:0] er);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end while (!tr);
        rready <= 1'b0;
        last_rd = d;
        check({30'h0, r}, {30'h0, er});
        check(d & rd_mask, exp & rd_mask);
    endtask
    function automatic logic [7:0] fa(input logic [4:0] i);
        return sse_pkg::OFF_FILE_BASE | {1'b0, i, 2'b00};
    endfunction
    initial begin
        #200000;
        num_errors++;
        give_verdict();
    end
    initial begin
        logic [31:0] e;
        logic [7:0] f, w, res;
        logic [2:0] fl;
        logic [1:0] ok;
        ok = sse_pkg::RESP_OKAY;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(sse_pkg::OFF_STATUS, 32'h18, ok);
        rd(sse_pkg::OFF_ACC, 32'h0, ok);
        rd(sse_pkg::OFF_OPTION, 32'h1, ok);
        rd(8'h40, 32'h0, sse_pkg::RESP_SLVERR);
        wr(8'h40, 32'h5, sse_pkg::RESP_SLVERR);
        for (int i = 0; i < 6; i++) begin
            e = SUBT[i];
            f = e[31:24];
            w = e[23:16];
            res = f - w;
            fl = {res == 8'h0, f[3:0] >= w[3:0], f >= w};
            wr(fa(e[4:0]), {24'h0, f}, ok);
            wr(sse_pkg::OFF_ACC, {24'h0, w}, ok);
            wr(sse_pkg::OFF_INSTR, {20'h0, sse_pkg::OP_SUB_HI, e[8],
                e[4:0]}, ok);
            rd(sse_pkg::OFF_ACC, {24'h0, e[8] ? w : res}, ok);
            rd(fa(e[4:0]), {24'h0, e[8] ? res : f}, ok);
            rd(sse_pkg::OFF_STATUS, {27'h3, fl}, ok);
        end
        for (int i = 0; i < 2; i++) begin
            e = SWPT[i];
            f = e[31:24];
            res = {f[3:0], f[7:4]};
            wr(fa(e[4:0]), {24'h0, f}, ok);
            wr(sse_pkg::OFF_ACC, 32'h77, ok);
            wr(sse_pkg::OFF_INSTR, {20'h0, sse_pkg::OP_SWAP_HI, e[8],
                e[4:0]}, ok);
            rd(sse_pkg::OFF_ACC, {24'h0, e[8] ? 8'h77 : res}, ok);
            rd(fa(e[4:0]), {24'h0, e[8] ? res : f}, ok);
            rd(sse_pkg::OFF_STATUS, {27'h3, fl}, ok);
        end
        // Count runs every tick with the prescaler unassigned
        wr(sse_pkg::OFF_OPTION, 32'h0, ok);
        repeat (100) @(posedge aclk);
        wr(sse_pkg::OFF_INSTR, {20'h0, sse_pkg::OP_SLEEP}, ok);
        @(negedge aclk);
        check({31'h0, osc_run}, 32'h0);
        rd(sse_pkg::OFF_STATUS, {27'h2, fl}, ok);
        // Count restarted from zero; unassigned prescaler keeps its value
        rd_mask = 32'h0000_00fc;
        rd(sse_pkg::OFF_WDOG, 32'h0, ok);
        rd_mask = 32'hffff_ffff;
        check({31'h0, last_rd[15:8] != 8'h00}, 32'h1);
        wr(sse_pkg::OFF_ACC, 32'h0, ok);
        rd(sse_pkg::OFF_ACC, 32'h0, ok);
        for (int n = 0; n < 2000 && osc_run !== 1'b1; n++) @(negedge aclk);
        rd(sse_pkg::OFF_STATUS, {27'h0, fl}, ok);
        // Prescaler assigned: it is cleared too, and expired flag set
        wr(sse_pkg::OFF_OPTION, 32'h1, ok);
        repeat (100) @(posedge aclk);
        wr(sse_pkg::OFF_INSTR, {20'h0, sse_pkg::OP_SLEEP}, ok);
        rd(sse_pkg::OFF_STATUS, {27'h2, fl}, ok);
        // Count zero, prescaler restarted and only a few ticks old
        rd_mask = 32'h0000_f0ff;
        rd(sse_pkg::OFF_WDOG, 32'h0, ok);
        rd_mask = 32'hffff_ffff;
        wr(sse_pkg::OFF_CTRL, 32'h0, ok);
        @(negedge aclk);
        check({31'h0, osc_run}, 32'h1);
        give_verdict();
    end
endmodule // sse_top_test
